// File: rtl/spf_params.svh
// Constants of the self-programming flash control block.
// Assumes a 20 MHz system clock and a 32-bit classic Wishbone slave port.
`ifndef SPF_PARAMS_SVH
`define SPF_PARAMS_SVH

// -----------------------------------------------------------------
// Register byte offsets
// -----------------------------------------------------------------
`define SPF_ADR_CTRL     8'h00
`define SPF_ADR_LOCK     8'h04
`define SPF_ADR_W        8

// -----------------------------------------------------------------
// Control register bits
// -----------------------------------------------------------------
`define SPF_B_IE         7
`define SPF_B_RWWB       6
`define SPF_B_RSV        5
`define SPF_B_RRE        4
`define SPF_B_BLB        3
`define SPF_B_PGW        2
`define SPF_B_PGE        1
`define SPF_B_EN         0
`define SPF_CTRL_RST     8'h00

// Accepted lower five control bit patterns
`define SPF_PAT_RRE      5'h11
`define SPF_PAT_BLB      5'h09
`define SPF_PAT_PGW      5'h05
`define SPF_PAT_PGE      5'h03
`define SPF_PAT_LOAD     5'h01
`define SPF_CMD_NONE     4'h0

// -----------------------------------------------------------------
// Lock byte
// -----------------------------------------------------------------
`define SPF_LK_LB1       0
`define SPF_LK_LB2       1
`define SPF_LK_APP_SECTION_LOCK_LO     2
`define SPF_LK_APP_SECTION_LOCK_HI     3
`define SPF_LK_BOOT_SECTION_LOCK_LO     4
`define SPF_LK_BOOT_SECTION_LOCK_HI     5
`define SPF_LOCK_RST     8'hff
`define SPF_BLB_MASK     8'h3c

// -----------------------------------------------------------------
// Flash geometry
// -----------------------------------------------------------------
`define SPF_STALL_SECTION_PAGE    8'he0
`define SPF_BOOT_P256    8'hfc
`define SPF_BOOT_P512    8'hf8
`define SPF_BOOT_P1K     8'hf0
`define SPF_BOOT_P2K     8'he0
`define SPF_FH_BSZ_HI    2
`define SPF_FH_BSZ_LO    1
`define SPF_ZP_PAGE_HI   14
`define SPF_ZP_PAGE_LO   7
`define SPF_ZP_WORD_HI   6
`define SPF_ZP_WORD_LO   1
`define SPF_ZP_BYTE      0
`define SPF_BUF_WORDS    64
`define SPF_ERASED_WORD  16'hffff

// -----------------------------------------------------------------
// Timing
// -----------------------------------------------------------------
`define SPF_SPM_WIN      2'h3
`define SPF_LPM_WIN      2'h3
`define SPF_PROG_MIN_NS  3700000
`define SPF_PROG_MAX_NS  4500000
`define SPF_CLK_NS       50
`define SPF_CNT_W        17

`endif

// File: rtl/spf_pkg.sv
// Types of the self-programming flash control block.
// Assumes spf_params.svh for all numeric constants.
package spf_pkg;

  typedef struct packed {
    logic        spm;
    logic        lpm;
    logic        from_boot;
    logic [15:0] z;
    logic [7:0]  r1;
    logic [7:0]  r0;
  } spf_cpu_req_t;

  typedef enum logic [1:0] {
    SPF_IDLE = 2'b01,
    SPF_BUSY = 2'b10
  } spf_state_t;

  typedef enum logic [2:0] {
    SPF_OP_ERASE = 3'b001,
    SPF_OP_WRITE = 3'b010,
    SPF_OP_LOCK  = 3'b100
  } spf_op_t;

endpackage

// File: rtl/spf_ctrl.sv
// Self-programming flash control: arming register, page buffer,
// timed erase/write/lock sequencer and lock-bit protection.
// Assumes a CPU that presents store/load-program requests as one-cycle
// strobes in cpu_req and a classic Wishbone master for the registers.
//
// Summary of operation
// - Ready interrupt requested while enabled, global enable set, spm_enable clear.
// - Erase/write into concurrent section sets rww_busy and blocks that section.
// - rww_busy clears by read-enable store after completion, or buffer load.
// - Control bit five is reserved and reads zero.
// - Read-enable plus store within four clocks re-enables section; refused busy.
// - Writing rww_read_enable during buffer loading discards loaded data.
// - Boot-lock store programs boot lock bits from r0, ignores r1, pointer.
// - Command bits self-clear on completion or unused four-clock window.
// - Load within three cycles of boot-lock arming returns lock or fuse.
// - Page-write store writes buffer to pointer page; data registers ignored.
// - Page-erase store erases pointer page; data registers ignored.
// - CPU halted during erase or write of the stall section.
// - Plain store loads r1:r0 into buffer word; pointer bit zero ignored.
// - spm_enable opens four clocks; clears on use, expiry, op end.
// - Undefined lower five bit patterns arm nothing.
// - Six lock bits, zero programmed; only chip erase or arst_n reset restores ones.
// - Memory lock mode two blocks external programming and locks fuses.
// - Memory lock mode three also blocks external verification.
// - Application lock low bit zero rejects stores into application.
// - Application lock high bit zero denies boot loads, masks interrupts.
// - Boot lock low bit zero rejects stores into boot section.
// - Boot lock high bit zero denies application loads, masks interrupts.
// - Erase, write and lock programming are self-timed within limits.
// - Page from pointer bits fourteen to seven, word from six to one.
//
// The Wishbone register port and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "spf_params.svh"

module spf_ctrl
  import spf_pkg::*;
#(
  parameter int PROG_CYCLES =
    (`SPF_PROG_MIN_NS + `SPF_CLK_NS - 1) / `SPF_CLK_NS
) (
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic         wb_cyc_i,
  input  wire logic         wb_stb_i,
  input  wire logic         wb_we_i,
  input  wire logic [7:0]   wb_adr_i,
  input  wire logic [3:0]   wb_sel_i,
  input  wire logic [31:0]  wb_dat_i,
  output logic      [31:0]  wb_dat_o,
  output logic              wb_ack_o,
  input  spf_cpu_req_t      cpu_req,
  input  wire logic         gie,
  input  wire logic         ivec_in_boot,
  input  wire logic [7:0]   fuse_low,
  input  wire logic [7:0]   fuse_high,
  input  wire logic         chip_erase,
  input  wire logic [5:0]   buf_rd_sel,
  output logic      [15:0]  buf_rd_data,
  output logic      [7:0]   lpm_data,
  output logic              lpm_override,
  output logic              lpm_denied,
  output logic              spm_denied,
  output logic              flash_erase,
  output logic              flash_write,
  output logic      [7:0]   flash_page,
  output logic              cpu_halt,
  output logic              rww_access_block,
  output logic              spm_irq,
  output logic              app_irq_off,
  output logic              boot_irq_off,
  output logic              ext_prog_lock,
  output logic              ext_verify_lock,
  output logic              fuse_lock
);

  // ---------------------------------------------------------------
  // Decoding helpers
  // ---------------------------------------------------------------
  function automatic logic in_boot(input logic [7:0] pg,
                                   input logic [1:0] bsz);
    logic [7:0] first;
    case (bsz)
      2'h3:    first = `SPF_BOOT_P256;
      2'h2:    first = `SPF_BOOT_P512;
      2'h1:    first = `SPF_BOOT_P1K;
      default: first = `SPF_BOOT_P2K;
    endcase
    return pg >= first;
  endfunction

  function automatic logic is_cmd(input logic [4:0] p);
    return (p == `SPF_PAT_RRE) || (p == `SPF_PAT_BLB) ||
           (p == `SPF_PAT_PGW) || (p == `SPF_PAT_PGE) ||
           (p == `SPF_PAT_LOAD);
  endfunction

  localparam logic [`SPF_CNT_W-1:0] PROG_LAST =
    `SPF_CNT_W'(PROG_CYCLES - 1);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  spf_state_t               state;
  spf_op_t                  op;
  logic [`SPF_CNT_W-1:0]    op_cnt;
  logic [7:0]               op_r0;
  logic                     op_stall_section, irq_en, rww_busy, spm_enable;
  logic [3:0]               cmd;
  logic [1:0]               win_cnt, lpm_cnt;
  logic [7:0]               lock;
  logic [15:0]              page_buf [`SPF_BUF_WORDS];
  logic [`SPF_BUF_WORDS-1:0] buf_val;

  logic                     wb_req, wb_wr, ctrl_wr, arm_ok, armed;
  logic                     spm_go, is_pg, is_load, is_rre, is_blb;
  logic                     spm_blk, starts_busy, done, tgt_boot;
  logic [7:0]               zp_page, ctrl_rd;
  logic [5:0]               zp_word;
  logic [1:0]               bsz;

  assign bsz     = {fuse_high[`SPF_FH_BSZ_HI], fuse_high[`SPF_FH_BSZ_LO]};
  assign zp_page = cpu_req.z[`SPF_ZP_PAGE_HI:`SPF_ZP_PAGE_LO];
  assign zp_word = cpu_req.z[`SPF_ZP_WORD_HI:`SPF_ZP_WORD_LO];
  assign tgt_boot = in_boot(zp_page, bsz);

  // ---------------------------------------------------------------
  // Wishbone slave
  // ---------------------------------------------------------------
  // Registered ack: one wait state, writes land on the ack edge
  assign wb_req  = wb_cyc_i & wb_stb_i;
  assign wb_wr   = wb_req & wb_we_i & wb_ack_o & wb_sel_i[0];
  assign ctrl_wr = wb_wr & (wb_adr_i == `SPF_ADR_CTRL);
  assign ctrl_rd = {irq_en, rww_busy, 1'b0, cmd, spm_enable};

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_req & ~wb_ack_o;
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (wb_req && !wb_ack_o) begin
      case (wb_adr_i)
        `SPF_ADR_CTRL: wb_dat_o <= {24'h00_0000, ctrl_rd};
        `SPF_ADR_LOCK: wb_dat_o <= {24'h00_0000, lock};
        default:       wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Arming and command decode
  // ---------------------------------------------------------------
  // Re-arming is refused while a timed operation runs
  assign arm_ok  = ctrl_wr & (state == SPF_IDLE) &
                   is_cmd(wb_dat_i[4:0]);
  assign armed   = spm_enable & (state == SPF_IDLE);
  assign spm_go  = armed & cpu_req.spm;
  assign is_pg   = cmd[`SPF_B_PGW-1] | cmd[`SPF_B_PGE-1];
  assign is_load = (cmd == `SPF_CMD_NONE);
  assign is_rre  = cmd[`SPF_B_RRE-1];
  assign is_blb  = cmd[`SPF_B_BLB-1];
  assign spm_blk = is_pg & (tgt_boot ? ~lock[`SPF_LK_BOOT_SECTION_LOCK_LO]
                                     : ~lock[`SPF_LK_APP_SECTION_LOCK_LO]);
  assign starts_busy = (is_pg & ~spm_blk) | is_blb;
  assign done    = (state == SPF_BUSY) & (op_cnt == '0);
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_en <= 1'b0;
    end else if (ctrl_wr) begin
      irq_en <= wb_dat_i[`SPF_B_IE];
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      spm_enable <= 1'b0;
      cmd        <= `SPF_CMD_NONE;
      win_cnt    <= 2'h0;
    end else if (arm_ok) begin
      spm_enable <= 1'b1;
      cmd        <= wb_dat_i[4:1];
      win_cnt    <= `SPF_SPM_WIN;
    end else if (done || (spm_go && !starts_busy) ||
                 (armed && !spm_go && win_cnt == 2'h0)) begin
      spm_enable <= 1'b0;
      cmd        <= `SPF_CMD_NONE;
    end else if (armed && !spm_go) begin
      win_cnt <= win_cnt - 2'h1;
    end
  end

  // Window for reading lock and fuse bytes by program load
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lpm_cnt <= 2'h0;
    end else if (arm_ok && wb_dat_i[4:0] == `SPF_PAT_BLB) begin
      lpm_cnt <= `SPF_LPM_WIN;
    end else if (lpm_cnt != 2'h0) begin
      lpm_cnt <= lpm_cnt - 2'h1;
    end
  end

  // ---------------------------------------------------------------
  // Timed operation sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state   <= SPF_IDLE;
      op      <= SPF_OP_ERASE;
      op_cnt  <= '0;
      op_stall_section <= 1'b0;
      op_r0   <= 8'hff;
    end else begin
      case (state)
        SPF_IDLE: begin
          if (spm_go && starts_busy) begin
            state   <= SPF_BUSY;
            op_cnt  <= PROG_LAST;
            op_r0   <= cpu_req.r0;
            op_stall_section <= is_pg & (zp_page >= `SPF_STALL_SECTION_PAGE);
            op      <= is_blb ? SPF_OP_LOCK :
                       cmd[`SPF_B_PGW-1] ? SPF_OP_WRITE :
                       SPF_OP_ERASE;
          end
        end
        SPF_BUSY: begin
          if (op_cnt == '0) begin
            state <= SPF_IDLE;
          end else begin
            op_cnt <= op_cnt - `SPF_CNT_W'(1);
          end
        end
        default: state <= SPF_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      flash_erase <= 1'b0;
      flash_write <= 1'b0;
      flash_page  <= 8'h00;
      spm_denied  <= 1'b0;
    end else begin
      flash_erase <= spm_go & is_pg & ~spm_blk & cmd[`SPF_B_PGE-1];
      flash_write <= spm_go & is_pg & ~spm_blk & cmd[`SPF_B_PGW-1];
      spm_denied  <= spm_go & spm_blk;
      if (spm_go && is_pg) begin
        flash_page <= zp_page;
      end
    end
  end

  // Busy flag of the concurrently readable section; set beats clear
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rww_busy <= 1'b0;
    end else if (spm_go && is_pg && !spm_blk &&
                 zp_page < `SPF_STALL_SECTION_PAGE) begin
      rww_busy <= 1'b1;
    end else if (spm_go && (is_rre || is_load)) begin
      rww_busy <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Temporary page buffer
  // ---------------------------------------------------------------
  // Unloaded words read back erased so a partial page stays blank
  always_ff @(posedge clk) begin
    if (spm_go && is_load) begin
      page_buf[zp_word] <= {cpu_req.r1, cpu_req.r0};
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      buf_val <= '0;
    end else if (spm_go && is_load) begin
      buf_val[zp_word] <= 1'b1;
    end else if (ctrl_wr && wb_dat_i[`SPF_B_RRE]) begin
      buf_val <= '0;
    end else if (done && op == SPF_OP_WRITE) begin
      buf_val <= '0;
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      buf_rd_data <= `SPF_ERASED_WORD;
    end else begin
      buf_rd_data <= buf_val[buf_rd_sel] ? page_buf[buf_rd_sel]
                                         : `SPF_ERASED_WORD;
    end
  end

  // ---------------------------------------------------------------
  // Lock bits
  // ---------------------------------------------------------------
  // Programming only clears bits; chip erase or arst_n reset is the only way back
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lock <= `SPF_LOCK_RST;
    end else if (chip_erase) begin
      lock <= `SPF_LOCK_RST;
    end else if (done && op == SPF_OP_LOCK) begin
      lock <= lock & (op_r0 | ~`SPF_BLB_MASK);
    end
  end

  // ---------------------------------------------------------------
  // Program-load path
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lpm_data     <= 8'h00;
      lpm_override <= 1'b0;
      lpm_denied   <= 1'b0;
    end else begin
      lpm_override <= cpu_req.lpm & (lpm_cnt != 2'h0);
      lpm_denied   <= cpu_req.lpm & (lpm_cnt == 2'h0) &
        ((cpu_req.from_boot & ~tgt_boot & ~lock[`SPF_LK_APP_SECTION_LOCK_HI]) |
         (~cpu_req.from_boot & tgt_boot & ~lock[`SPF_LK_BOOT_SECTION_LOCK_HI]) |
         (rww_busy & (zp_page < `SPF_STALL_SECTION_PAGE)));
      if (cpu_req.lpm) begin
        lpm_data <= cpu_req.z[`SPF_ZP_BYTE] ? lock : fuse_low;
      end
    end
  end

  // ---------------------------------------------------------------
  // Status outputs
  // ---------------------------------------------------------------
  assign cpu_halt         = (state == SPF_BUSY) & op_stall_section;
  assign rww_access_block = rww_busy;
  assign spm_irq          = irq_en & gie & ~spm_enable;
  assign app_irq_off  = ~lock[`SPF_LK_APP_SECTION_LOCK_HI] & ivec_in_boot &
                        ~cpu_req.from_boot;
  assign boot_irq_off = ~lock[`SPF_LK_BOOT_SECTION_LOCK_HI] & ~ivec_in_boot &
                        cpu_req.from_boot;
  assign ext_prog_lock   = ~lock[`SPF_LK_LB1];
  assign ext_verify_lock = ~lock[`SPF_LK_LB1] &
                           ~lock[`SPF_LK_LB2];
  assign fuse_lock       = ~lock[`SPF_LK_LB1];

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  AST_IRQ_IDLE: assert property (
    (irq_en && gie && state == SPF_IDLE && !armed) |-> spm_irq)
    else $error("ready interrupt missing while idle");
  AST_RSV_ZERO: assert property (
    (wb_ack_o && !wb_we_i && wb_adr_i == `SPF_ADR_CTRL)
      |-> wb_dat_o[`SPF_B_RSV] == 1'b0)
    else $error("reserved bit read as one");
  AST_WIN_EXPIRE: assert property (
    ($rose(spm_enable) && !cpu_req.spm) ##1 (!cpu_req.spm)[*3]
      |=> !spm_enable)
    else $error("store window outlived four clocks");
  AST_RWW_SET: assert property (
    (spm_go && is_pg && !spm_blk && zp_page < `SPF_STALL_SECTION_PAGE)
      |=> rww_busy && rww_access_block)
    else $error("rww busy not set");
  AST_RWW_CLR: assert property (
    (spm_go && is_load) |=> !rww_busy)
    else $error("buffer load did not clear rww busy");
  AST_BUSY_HOLD: assert property (
    (state == SPF_BUSY) |-> spm_enable)
    else $error("spm_enable dropped during operation");
  AST_HALT: assert property (
    $rose(cpu_halt) |-> $past(spm_go) && $past(zp_page) >= `SPF_STALL_SECTION_PAGE)
    else $error("halt without stall section operation");
  AST_LOCK_DOWN: assert property (
    !chip_erase |=> (lock & ~$past(lock)) == 8'h00)
    else $error("lock bit returned to one");
  AST_BAD_CMD: assert property (
    (ctrl_wr && !is_cmd(wb_dat_i[4:0]) && !spm_enable) |=> !spm_enable)
    else $error("undefined pattern armed a store");
  AST_SPM_REJECT: assert property (
    (spm_go && spm_blk) |=> state == SPF_IDLE && spm_denied)
    else $error("locked section store not rejected");
  AST_VERIFY: assert property (
    ext_verify_lock |-> ext_prog_lock && fuse_lock)
    else $error("verify lock without program lock");
  COV_LOAD:  cover property (spm_go && is_load);
  COV_ERASE: cover property (flash_erase ##1 cpu_halt);
  COV_LOCK:  cover property (done && op == SPF_OP_LOCK);
  COV_LPM:   cover property (lpm_override);

endmodule // spf_ctrl

// File: sim/spf_cpu_model.sv
// CPU core model: issues one-cycle store and load-program strobes.
// Assumes callers enter its task just after a rising clock edge.
`timescale 1ns/1ps
module spf_cpu_model
  import spf_pkg::*;
(
  input  wire logic    clk,
  input  wire logic    cpu_halt,
  output spf_cpu_req_t cpu_req
);
  initial cpu_req = '0;

  // ------------------------------------------------------------
  // Strobe issue
  // ------------------------------------------------------------
  task automatic issue(input logic st, input logic [15:0] z,
    input logic [7:0] r1, input logic [7:0] r0, input logic fb);
    while (cpu_halt === 1'b1) @(posedge clk);
    cpu_req.spm       <= st;
    cpu_req.lpm       <= !st;
    cpu_req.z         <= z;
    cpu_req.r1        <= r1;
    cpu_req.r0        <= r0;
    cpu_req.from_boot <= fb;
    @(posedge clk);
    cpu_req.spm <= 1'b0;
    cpu_req.lpm <= 1'b0;
    // Operands not held past the strobe
    cpu_req.z   <= ~z;
    cpu_req.r1  <= ~r1;
    cpu_req.r0  <= ~r0;
  endtask
endmodule // spf_cpu_model

// File: sim/testbench.sv
// Self-checking bench for spf_ctrl with a CPU model on cpu_req.
// Assumes the design's own assertions are compiled with it.
`timescale 1ns/1ps
module testbench
  import spf_pkg::*;
();
  logic clk = 1'b0, arst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic gie = 1'b0, ce = 1'b0, ack, ovr, lden, sden, fer, fwr;
  logic halt, rwwb, irq, aoff, boff, eprg, ever, flck, ivb = 1'b1;
  logic [7:0] adr = 8'h00, lpmd, fpg;
  logic [31:0] wdat = 32'h0000_0000, rdat, dat_o;
  logic [5:0] bsel = 6'h00;
  logic [15:0] bufd;
  spf_cpu_req_t creq;
  int error_cnt = 0, num_checks = 0;

  always #25 clk = ~clk;

  spf_cpu_model cpu (.clk(clk), .cpu_halt(halt), .cpu_req(creq));
  // Fuses fixed before any lock programming, boot start page 0xE0
  spf_ctrl #(.PROG_CYCLES(8)) dut (.clk(clk), .arst_n(arst_n),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .cpu_req(creq), .gie(gie), .ivec_in_boot(ivb),
    .fuse_low(8'he1), .fuse_high(8'hf9),
    .chip_erase(ce), .buf_rd_sel(bsel), .buf_rd_data(bufd),
    .lpm_data(lpmd), .lpm_override(ovr), .lpm_denied(lden),
    .spm_denied(sden), .flash_erase(fer), .flash_write(fwr),
    .flash_page(fpg), .cpu_halt(halt), .rww_access_block(rwwb),
    .spm_irq(irq), .app_irq_off(aoff), .boot_irq_off(boff),
    .ext_prog_lock(eprg), .ext_verify_lock(ever), .fuse_lock(flck));

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= {24'h00_0000, d};
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    rdat = dat_o;
    cyc  <= 1'b0;
    stb  <= 1'b0;
    wdat <= ~wdat;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 8'h00);
    chk(rdat, exp);
  endtask

  task automatic bufc(input logic [5:0] s, input logic [15:0] exp);
    bsel <= s;
    @(posedge clk);
    @(negedge clk);
    chk(bufd, exp);
    @(posedge clk);
  endtask

  task automatic end_sim;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_regs;
    rd(8'h00, 32'h0000_0000);
    rd(8'h04, 32'h0000_00ff);
    rd(8'h08, 32'h0000_0000);
    wb(1'b1, 8'h00, 8'h07);
    rd(8'h00, 32'h0000_0000);
  endtask

  task automatic t_load;
    wb(1'b1, 8'h00, 8'h01);
    cpu.issue(1'b1, 16'h0003, 8'h12, 8'h34, 1'b0);
    rd(8'h00, 32'h0000_0000);
    bufc(6'd1, 16'h1234);
    wb(1'b1, 8'h00, 8'h01);
    repeat (5) @(posedge clk);
    cpu.issue(1'b1, 16'h0004, 8'h56, 8'h78, 1'b0);
    rd(8'h00, 32'h0000_0000);
    bufc(6'd2, 16'hffff);
    wb(1'b1, 8'h00, 8'h11);
    bufc(6'd1, 16'hffff);
    repeat (4) @(posedge clk);
  endtask

  task automatic t_erase;
    wb(1'b1, 8'h00, 8'h03);
    cpu.issue(1'b1, 16'h0280, 8'haa, 8'h55, 1'b0);
    @(negedge clk);
    chk(fer, 1'b1);
    chk(fpg, 8'h05);
    chk(rwwb, 1'b1);
    chk(halt, 1'b0);
    @(posedge clk);
    rd(8'h00, 32'h0000_0043);
    wb(1'b1, 8'h00, 8'h11);
    repeat (12) @(posedge clk);
    rd(8'h00, 32'h0000_0040);
    wb(1'b1, 8'h00, 8'h11);
    cpu.issue(1'b1, 16'h0000, 8'h00, 8'h00, 1'b0);
    rd(8'h00, 32'h0000_0000);
    wb(1'b1, 8'h00, 8'h05);
    cpu.issue(1'b1, 16'h7100, 8'h00, 8'h00, 1'b0);
    @(negedge clk);
    chk(fwr, 1'b1);
    chk(halt, 1'b1);
    chk(rwwb, 1'b0);
    repeat (12) @(posedge clk);
    rd(8'h00, 32'h0000_0000);
  endtask

  task automatic t_irq;
    wb(1'b1, 8'h00, 8'h80);
    gie <= 1'b1;
    @(negedge clk);
    chk(irq, 1'b1);
    @(posedge clk);
    wb(1'b1, 8'h00, 8'h81);
    @(negedge clk);
    chk(irq, 1'b0);
    repeat (6) @(posedge clk);
    chk(irq, 1'b1);
    gie <= 1'b0;
    wb(1'b1, 8'h00, 8'h00);
  endtask

  task automatic t_lock;
    wb(1'b1, 8'h00, 8'h09);
    cpu.issue(1'b0, 16'h0001, 8'h00, 8'h00, 1'b0);
    @(negedge clk);
    chk(lpmd, 8'hff);
    chk(ovr, 1'b1);
    @(posedge clk);
    cpu.issue(1'b1, 16'hffff, 8'hff, 8'hc0, 1'b0);
    repeat (12) @(posedge clk);
    rd(8'h04, 32'h0000_00c3);
    chk({eprg, ever, flck}, 3'h0);
    wb(1'b1, 8'h00, 8'h03);
    cpu.issue(1'b1, 16'h0000, 8'h00, 8'h00, 1'b0);
    @(negedge clk);
    chk(sden, 1'b1);
    chk(fer, 1'b0);
    @(posedge clk);
    wb(1'b1, 8'h00, 8'h03);
    cpu.issue(1'b1, 16'h7100, 8'h00, 8'h00, 1'b0);
    @(negedge clk);
    chk({sden, fer}, 2'h2);
    @(posedge clk);
    cpu.issue(1'b0, 16'h0000, 8'h00, 8'h00, 1'b1);
    @(negedge clk);
    chk(lden, 1'b1);
    @(posedge clk);
    cpu.issue(1'b0, 16'h7100, 8'h00, 8'h00, 1'b0);
    @(negedge clk);
    chk(lden, 1'b1);
    chk(aoff, 1'b1);
    @(posedge clk);
    ivb <= 1'b0;
    cpu.issue(1'b0, 16'h7100, 8'h00, 8'h00, 1'b1);
    @(negedge clk);
    chk({boff, aoff, lden}, 3'h4);
    @(posedge clk);
    ce <= 1'b1;
    @(posedge clk);
    ce <= 1'b0;
    rd(8'h04, 32'h0000_00ff);
  endtask

  initial begin
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_load();
    t_erase();
    t_irq();
    t_lock();
    end_sim();
  end

  // Whole sequence needs well under 1000 cycles
  initial begin
    repeat (4000) @(posedge clk);
    error_cnt++;
    end_sim();
  end
endmodule // testbench
